// >>> verilog/tspr_pin_router.sv
/*
  timing-signal pin router: drives the dedicated timing outputs of the
  connector and the ten programmable function pins, and routes external
  levels from input pins to the timing functions.
  roles of the function pins when they drive:
    pin 0 acquisition start trigger, high for the whole acquisition
    pin 1 acquisition stop trigger, high from the posttrigger start of a pretrigger acquisition to the end
    pin 2 convert strobe, active low, one pulse per conversion
    pin 3 counter 1 source copy
    pin 4 counter 1 gate copy
    pin 5 output update strobe, active low, one pulse per update
    pin 6 waveform start trigger, high while the waveform runs
    pin 7 scan start pulse, one per scan
    pin 8 counter 0 source copy
    pin 9 counter 0 gate copy
  a pin set as input drives 0 and passes its level on one cycle later;
  dedicated counter and frequency outputs are registered copies of their sources, one cycle late.
  assumes the acquisition engine, output engine, counters and frequency
  generator deliver single-cycle events and levels synchronous to CLK_SYS;
  the pad logic resolves each pin from its output and output enable;
  reset holds for at least one clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - in scanning mode with scan clock enabled, one pulse per conversion.
// - scan clock rising edge marks when the sampled input may be released.
// - software toggles an active-low external strobe output.
// - every function pin set as input passes its level to the timing functions.
// - pin 0 start trigger rises when a posttrigger acquisition begins.
// - in pretrigger operation start trigger rises as pretrigger conversions begin.
// - pin 1 stop trigger rises when posttrigger conversions begin in pretrigger mode.
// - stop trigger stays idle during posttrigger-only acquisitions.
// - pin 2 active-low convert strobe falls once per conversion.
// - pins 3 and 4 copy the selected source and gate of counter 1.
// - pins 8 and 9 copy the selected source and gate of counter 0.
// - a dedicated pin carries the output of counter 1.
// - a dedicated pin carries the output of counter 0.
// - pin 5 active-low update strobe falls at each primary output group update.
// - pin 6 waveform trigger rises when waveform generation begins.
// - pin 7 pulses once per scan, rising edge at scan start.
// - a dedicated pin carries the frequency generator output.
module tspr_pin_router #(
  parameter int NUM_FUNC_PINS = tspr_pkg::NUM_FUNC_PINS,
  parameter int PULSE_CYC = tspr_pkg::PULSE_CYC,
  parameter int PEND_W = 4
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [NUM_FUNC_PINS-1:0] FUNC_PIN_DIR,
  input wire logic [NUM_FUNC_PINS-1:0] FUNC_PIN_IN,
  output logic [NUM_FUNC_PINS-1:0] FUNC_PIN_OUT,
  output logic [NUM_FUNC_PINS-1:0] FUNC_PIN_OE_N,
  output logic [NUM_FUNC_PINS-1:0] FUNC_PIN_ROUTED,
  input wire logic SCAN_MODE,
  input wire logic SCAN_CLOCK_EN,
  input wire logic AI_CONVERT,
  input wire logic AI_SCAN_BEGIN,
  input wire logic PRETRIG_MODE,
  input wire logic ACQ_BEGIN,
  input wire logic POST_BEGIN,
  input wire logic ACQ_END,
  input wire logic AO_UPDATE,
  input wire logic AO_WAVE_BEGIN,
  input wire logic AO_WAVE_END,
  input wire logic CTR0_SOURCE_SEL,
  input wire logic CTR0_GATE_SEL,
  input wire logic CTR1_SOURCE_SEL,
  input wire logic CTR1_GATE_SEL,
  input wire logic CTR0_OUT_IN,
  input wire logic CTR1_OUT_IN,
  input wire logic FREQ_GEN_IN,
  input wire logic STROBE_TOGGLE,
  output logic SCAN_CLOCK_OUT,
  output logic EXTERNAL_STROBE_N,
  output logic COUNTER0_OUTPUT,
  output logic COUNTER1_OUTPUT,
  output logic FREQ_GENERATOR_OUTPUT,
  output logic ACQ_PRE_PHASE,
  output logic ACQ_POST_PHASE
);

  typedef struct packed {
    tspr_pkg::tspr_acq_e acq;
    logic acq_start_trigger;
    logic acq_stop_trigger;
    logic waveform_start_trigger;
    logic external_strobe_n;
    logic counter0_source_copy;
    logic counter0_gate_copy;
    logic counter1_source_copy;
    logic counter1_gate_copy;
    logic counter0_output;
    logic counter1_output;
    logic freq_generator_output;
  } tspr_router_s;

  tspr_router_s st;
  tspr_router_s next_st;

  logic scan_fire;
  logic scan_clock_out;
  logic convert_n;
  logic update_n;
  logic scan_start_pulse;
  logic [NUM_FUNC_PINS-1:0] drive;

  generate
    if (NUM_FUNC_PINS != 10) begin : g_bad_pins
      $error("tspr_pin_router: the pin roles need exactly ten function pins");
    end
    if (PULSE_CYC < 1) begin : g_bad_pulse
      $error("tspr_pin_router: pulse width must be at least one cycle");
    end
    if (PULSE_CYC > 65536) begin : g_long_pulse
      $error("tspr_pin_router: pulse width beyond the pulse counter");
    end
    if (PEND_W < 1) begin : g_bad_pend
      $error("tspr_pin_router: pending counter needs at least one bit");
    end
  endgenerate

  // phase decode shared by the status outputs
  function automatic logic phase_is(input tspr_pkg::tspr_acq_e now, input tspr_pkg::tspr_acq_e want);
    return now == want;
  endfunction : phase_is

  // scan clock: one pulse per conversion while scanning and enabled
  assign scan_fire = AI_CONVERT & SCAN_MODE & SCAN_CLOCK_EN;

  tspr_pulse_gen #(
    .WIDTH_CYC(PULSE_CYC),
    .ACTIVE_LOW(1'b0),
    .PEND_W(PEND_W)
  ) u_scan_clock (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .fire(scan_fire),
    .pulse(scan_clock_out)
  );

  // convert strobe, active low, falls per conversion
  tspr_pulse_gen #(
    .WIDTH_CYC(PULSE_CYC),
    .ACTIVE_LOW(1'b1),
    .PEND_W(PEND_W)
  ) u_convert (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .fire(AI_CONVERT),
    .pulse(convert_n)
  );

  // output update strobe, active low
  tspr_pulse_gen #(
    .WIDTH_CYC(PULSE_CYC),
    .ACTIVE_LOW(1'b1),
    .PEND_W(PEND_W)
  ) u_update (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .fire(AO_UPDATE),
    .pulse(update_n)
  );

  // scan start, rising edge at each scan
  tspr_pulse_gen #(
    .WIDTH_CYC(PULSE_CYC),
    .ACTIVE_LOW(1'b0),
    .PEND_W(PEND_W)
  ) u_scan_start (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .fire(AI_SCAN_BEGIN),
    .pulse(scan_start_pulse)
  );

  always_comb begin
    next_st = st;

    // acquisition sequence and its triggers
    unique case (st.acq)
      tspr_pkg::TSPR_ACQ_IDLE: begin
        // stop and end pulses while idle are ignored
        if (ACQ_BEGIN) begin
          next_st.acq_start_trigger = 1'b1;
          next_st.acq = PRETRIG_MODE ? tspr_pkg::TSPR_ACQ_PRE : tspr_pkg::TSPR_ACQ_POST;
        end
      end
      tspr_pkg::TSPR_ACQ_PRE: begin
        // a second start while active is ignored; end wins over posttrigger start
        if (ACQ_END) begin
          next_st.acq = tspr_pkg::TSPR_ACQ_IDLE;
          next_st.acq_start_trigger = 1'b0;
          next_st.acq_stop_trigger = 1'b0;
        end else if (POST_BEGIN) begin
          next_st.acq = tspr_pkg::TSPR_ACQ_POST;
          next_st.acq_stop_trigger = 1'b1;
        end
      end
      tspr_pkg::TSPR_ACQ_POST: begin
        // a posttrigger start here is ignored: no pretrigger phase to end
        if (ACQ_END) begin
          next_st.acq = tspr_pkg::TSPR_ACQ_IDLE;
          next_st.acq_start_trigger = 1'b0;
          next_st.acq_stop_trigger = 1'b0;
        end
      end
      default: begin
        next_st.acq = tspr_pkg::TSPR_ACQ_IDLE;
        next_st.acq_start_trigger = tspr_pkg::TRIGGER_RESET;
        next_st.acq_stop_trigger = tspr_pkg::TRIGGER_RESET;
      end
    endcase

    // waveform trigger: begin wins over end in the same cycle
    if (AO_WAVE_BEGIN) begin
      next_st.waveform_start_trigger = 1'b1;
    end else if (AO_WAVE_END) begin
      next_st.waveform_start_trigger = 1'b0;
    end

    // software strobe
    if (STROBE_TOGGLE) begin
      next_st.external_strobe_n = ~st.external_strobe_n;
    end

    // counter signal copies and dedicated outputs
    next_st.counter1_source_copy = CTR1_SOURCE_SEL;
    next_st.counter1_gate_copy = CTR1_GATE_SEL;
    next_st.counter0_source_copy = CTR0_SOURCE_SEL;
    next_st.counter0_gate_copy = CTR0_GATE_SEL;
    next_st.counter1_output = CTR1_OUT_IN;
    next_st.counter0_output = CTR0_OUT_IN;
    next_st.freq_generator_output = FREQ_GEN_IN;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '{
        acq: tspr_pkg::TSPR_ACQ_IDLE,
        acq_start_trigger: tspr_pkg::TRIGGER_RESET,
        acq_stop_trigger: tspr_pkg::TRIGGER_RESET,
        waveform_start_trigger: tspr_pkg::TRIGGER_RESET,
        external_strobe_n: tspr_pkg::STROBE_RESET,
        counter0_source_copy: 1'b0,
        counter0_gate_copy: 1'b0,
        counter1_source_copy: 1'b0,
        counter1_gate_copy: 1'b0,
        counter0_output: 1'b0,
        counter1_output: 1'b0,
        freq_generator_output: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // internal signal that each function pin drives as an output
  always_comb begin
    drive = '0;
    drive[tspr_pkg::PIN_ACQ_START] = st.acq_start_trigger;
    drive[tspr_pkg::PIN_ACQ_STOP] = st.acq_stop_trigger;
    drive[tspr_pkg::PIN_CONVERT] = convert_n;
    drive[tspr_pkg::PIN_CTR1_SOURCE] = st.counter1_source_copy;
    drive[tspr_pkg::PIN_CTR1_GATE] = st.counter1_gate_copy;
    drive[tspr_pkg::PIN_AO_UPDATE] = update_n;
    drive[tspr_pkg::PIN_WAVE_START] = st.waveform_start_trigger;
    drive[tspr_pkg::PIN_SCAN_START] = scan_start_pulse;
    drive[tspr_pkg::PIN_CTR0_SOURCE] = st.counter0_source_copy;
    drive[tspr_pkg::PIN_CTR0_GATE] = st.counter0_gate_copy;
  end

  for (genvar i = 0; i < NUM_FUNC_PINS; i++) begin : g_func_pin
    tspr_pin_cell u_cell (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .dir_out(FUNC_PIN_DIR[i]),
      .drive_val(drive[i]),
      .pin_in(FUNC_PIN_IN[i]),
      .pin_out(FUNC_PIN_OUT[i]),
      .pin_oe_n(FUNC_PIN_OE_N[i]),
      .routed(FUNC_PIN_ROUTED[i])
    );
  end

  // pulse outputs straight from their generators
  assign SCAN_CLOCK_OUT = scan_clock_out;
  // dedicated outputs
  assign EXTERNAL_STROBE_N = st.external_strobe_n;
  assign COUNTER0_OUTPUT = st.counter0_output;
  assign COUNTER1_OUTPUT = st.counter1_output;
  assign FREQ_GENERATOR_OUTPUT = st.freq_generator_output;
  // status outputs decode the phase register
  assign ACQ_PRE_PHASE = phase_is(st.acq, tspr_pkg::TSPR_ACQ_PRE);
  assign ACQ_POST_PHASE = phase_is(st.acq, tspr_pkg::TSPR_ACQ_POST);

endmodule : tspr_pin_router

`default_nettype wire

// >>> verilog/tspr_pkg.sv
/*
  package of the timing-signal pin router: pin indices, timing counts,
  reset values and state encodings.
  assumes the system clock of 40 MHz and nothing else of its surroundings.
*/
package tspr_pkg;

  // clock and pulse timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_MIN_NS = 50;
  localparam int PULSE_CYC_RAW = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;

  // number of programmable function pins and the role of each one
  localparam int NUM_FUNC_PINS = 10;
  localparam int PIN_ACQ_START = 0;
  localparam int PIN_ACQ_STOP = 1;
  localparam int PIN_CONVERT = 2;
  localparam int PIN_CTR1_SOURCE = 3;
  localparam int PIN_CTR1_GATE = 4;
  localparam int PIN_AO_UPDATE = 5;
  localparam int PIN_WAVE_START = 6;
  localparam int PIN_SCAN_START = 7;
  localparam int PIN_CTR0_SOURCE = 8;
  localparam int PIN_CTR0_GATE = 9;

  // reset values
  localparam logic STROBE_RESET = 1'h1;
  localparam logic TRIGGER_RESET = 1'h0;
  localparam logic OE_N_RESET = 1'h1;

  // acquisition sequence phase
  typedef enum logic [2:0] {
    TSPR_ACQ_IDLE = 3'h1,
    TSPR_ACQ_PRE = 3'h2,
    TSPR_ACQ_POST = 3'h4
  } tspr_acq_e;

  // pulse generator phase
  typedef enum logic [2:0] {
    TSPR_PULSE_IDLE = 3'h1,
    TSPR_PULSE_ACTIVE = 3'h2,
    TSPR_PULSE_GAP = 3'h4
  } tspr_pulse_e;

endpackage : tspr_pkg

// >>> verilog/tspr_pulse_gen.sv
/*
  pulse generator: one pulse of fixed width for every event not lost to a full pending counter, events that
  arrive during a pulse are counted and played out afterwards.
  assumes events are single-cycle pulses synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tspr_pulse_gen #(
  parameter int WIDTH_CYC = 2,
  parameter bit ACTIVE_LOW = 1'b0,
  parameter int PEND_W = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic fire,
  output logic pulse
);

  typedef struct packed {
    tspr_pkg::tspr_pulse_e phase;
    logic [15:0] cnt;
    logic [PEND_W-1:0] pend;
    logic level;
  } tspr_pulse_s;

  tspr_pulse_s st;
  tspr_pulse_s next_st;

  localparam logic [15:0] CNT_LOAD = 16'(WIDTH_CYC - 1);
  localparam logic [PEND_W-1:0] PEND_MAX = '1;

  generate
    if (WIDTH_CYC < 1 || WIDTH_CYC > 65536 || PEND_W < 1) begin : g_bad
      $error("tspr_pulse_gen: width or pending counter out of range");
    end
  endgenerate

  always_comb begin
    next_st = st;
    // every event is remembered; a saturated counter is the only loss
    if (fire && st.pend != PEND_MAX) begin
      next_st.pend = st.pend + 1'b1;
    end
    unique case (st.phase)
      tspr_pkg::TSPR_PULSE_IDLE: begin
        if (fire || st.pend != '0) begin
          next_st.pend = fire ? st.pend : st.pend - 1'b1;
          next_st.phase = tspr_pkg::TSPR_PULSE_ACTIVE;
          next_st.cnt = CNT_LOAD;
          next_st.level = 1'b1;
        end
      end
      tspr_pkg::TSPR_PULSE_ACTIVE: begin
        if (st.cnt == '0) begin
          next_st.phase = tspr_pkg::TSPR_PULSE_GAP;
          next_st.cnt = CNT_LOAD;
          next_st.level = 1'b0;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      tspr_pkg::TSPR_PULSE_GAP: begin
        if (st.cnt == '0) begin
          next_st.phase = tspr_pkg::TSPR_PULSE_IDLE;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      default: begin
        next_st.phase = tspr_pkg::TSPR_PULSE_IDLE;
        next_st.level = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{phase: tspr_pkg::TSPR_PULSE_IDLE, cnt: '0, pend: '0, level: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.level ^ ACTIVE_LOW;

endmodule : tspr_pulse_gen

`default_nettype wire

// >>> verilog/tspr_pin_cell.sv
/*
  one programmable function pin: drives its timing signal or passes the
  external level on to the timing functions, never both at once.
  assumes the pin level is already synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tspr_pin_cell (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic dir_out,
  input wire logic drive_val,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic routed
);

  typedef struct packed {
    logic out;
    logic oe_n;
    logic routed;
  } tspr_pin_s;

  tspr_pin_s st;
  tspr_pin_s next_st;

  always_comb begin
    next_st.oe_n = ~dir_out;
    next_st.out = dir_out ? drive_val : 1'b0;
    next_st.routed = dir_out ? 1'b0 : pin_in;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{out: 1'b0, oe_n: tspr_pkg::OE_N_RESET, routed: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.out;
  assign pin_oe_n = st.oe_n;
  assign routed = st.routed;

endmodule : tspr_pin_cell

`default_nettype wire

// >>> testbench/tspr_pin_router_checker.sv
/*
  port checker of the timing-signal pin router, bound to its top module.
  assumes the default pulse width of two cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module tspr_pin_router_checker #(
  parameter int NUM_FUNC_PINS = 10
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [NUM_FUNC_PINS-1:0] FUNC_PIN_DIR,
  input wire logic [NUM_FUNC_PINS-1:0] FUNC_PIN_IN,
  input wire logic [NUM_FUNC_PINS-1:0] FUNC_PIN_OUT,
  input wire logic [NUM_FUNC_PINS-1:0] FUNC_PIN_OE_N,
  input wire logic [NUM_FUNC_PINS-1:0] FUNC_PIN_ROUTED,
  input wire logic ACQ_BEGIN,
  input wire logic ACQ_PRE_PHASE,
  input wire logic ACQ_POST_PHASE,
  input wire logic CTR0_OUT_IN,
  input wire logic FREQ_GEN_IN,
  input wire logic STROBE_TOGGLE,
  input wire logic SCAN_CLOCK_OUT,
  input wire logic EXTERNAL_STROBE_N,
  input wire logic COUNTER0_OUTPUT,
  input wire logic FREQ_GENERATOR_OUTPUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  scan_pulse_a: assert property ($rose(SCAN_CLOCK_OUT) |=> SCAN_CLOCK_OUT ##1 !SCAN_CLOCK_OUT [*2])
    else $error("scan clock pulse width or gap wrong");
  strobe_flip_a: assert property (STROBE_TOGGLE |=> EXTERNAL_STROBE_N != $past(EXTERNAL_STROBE_N))
    else $error("strobe did not flip");
  strobe_hold_a: assert property (!STROBE_TOGGLE |=> $stable(EXTERNAL_STROBE_N))
    else $error("strobe moved without toggle");
  dir_enable_a: assert property ($past(ARST_N) |-> FUNC_PIN_OE_N == ~$past(FUNC_PIN_DIR))
    else $error("output enable does not follow direction");
  pin_route_a: assert property ($past(ARST_N) |->
    FUNC_PIN_ROUTED == ($past(FUNC_PIN_IN) & ~$past(FUNC_PIN_DIR)))
    else $error("routed level wrong");
  input_quiet_a: assert property ((FUNC_PIN_OUT & FUNC_PIN_OE_N) == '0)
    else $error("input pin carries a drive value");
  ctr0_copy_a: assert property ($past(ARST_N) |-> COUNTER0_OUTPUT == $past(CTR0_OUT_IN))
    else $error("counter 0 output copy wrong");
  freq_copy_a: assert property ($past(ARST_N) |-> FREQ_GENERATOR_OUTPUT == $past(FREQ_GEN_IN))
    else $error("frequency output copy wrong");
  start_trig_a: assert property (ACQ_BEGIN && !ACQ_PRE_PHASE && !ACQ_POST_PHASE && FUNC_PIN_DIR[0]
    ##1 FUNC_PIN_DIR[0] |=> FUNC_PIN_OUT[0])
    else $error("start trigger did not rise");
endmodule : tspr_pin_router_checker

bind tspr_pin_router tspr_pin_router_checker #(.NUM_FUNC_PINS(NUM_FUNC_PINS)) chk (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .FUNC_PIN_DIR(FUNC_PIN_DIR), .FUNC_PIN_IN(FUNC_PIN_IN),
  .FUNC_PIN_OUT(FUNC_PIN_OUT), .FUNC_PIN_OE_N(FUNC_PIN_OE_N), .FUNC_PIN_ROUTED(FUNC_PIN_ROUTED),
  .ACQ_BEGIN(ACQ_BEGIN), .ACQ_PRE_PHASE(ACQ_PRE_PHASE),
  .ACQ_POST_PHASE(ACQ_POST_PHASE), .CTR0_OUT_IN(CTR0_OUT_IN), .FREQ_GEN_IN(FREQ_GEN_IN),
  .STROBE_TOGGLE(STROBE_TOGGLE), .SCAN_CLOCK_OUT(SCAN_CLOCK_OUT), .EXTERNAL_STROBE_N(EXTERNAL_STROBE_N),
  .COUNTER0_OUTPUT(COUNTER0_OUTPUT), .FREQ_GENERATOR_OUTPUT(FREQ_GENERATOR_OUTPUT));

`default_nettype wire

// >>> testbench/tspr_ext_instr.sv
/*
  external instruments on the connector pins.
  assumes a pull-up on every function pin.
*/
`timescale 1ns/1ps
`default_nettype none

module tspr_ext_instr #(
  parameter int N = 10
) (
  input wire logic [N-1:0] drv_en,
  input wire logic [N-1:0] drv_val,
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe_n,
  output logic [N-1:0] pad
);
  // router drive first, then the instrument, else the pull-up
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pad[i] = !pin_oe_n[i] ? pin_out[i] : (drv_en[i] ? drv_val[i] : 1'b1);
    end
  end
endmodule : tspr_ext_instr

`default_nettype wire

// >>> testbench/tspr_pin_router_test.sv
/*
  self-checking testbench of the timing-signal pin router.
  assumes the default pulse width of two cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module tspr_pin_router_test;
  logic clk_sys, arst_n, scan_mode, scan_en, pretrig, s1, g1, s0, g0, c0, c1, fq;
  logic sco, stb_n, c0o, c1o, fqo, pre, post;
  logic [8:0] ev;
  logic [9:0] dir, pad, pout, oe_n, routed, drv_en, drv_val;
  int err_count, checks_done, n_scan, n_conv, n_upd, n_ss;

  tspr_pin_router dut (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .FUNC_PIN_DIR(dir), .FUNC_PIN_IN(pad), .FUNC_PIN_OUT(pout),
    .FUNC_PIN_OE_N(oe_n), .FUNC_PIN_ROUTED(routed), .SCAN_MODE(scan_mode), .SCAN_CLOCK_EN(scan_en),
    .AI_CONVERT(ev[6]), .AI_SCAN_BEGIN(ev[7]), .PRETRIG_MODE(pretrig), .ACQ_BEGIN(ev[0]), .POST_BEGIN(ev[1]),
    .ACQ_END(ev[2]), .AO_UPDATE(ev[8]), .AO_WAVE_BEGIN(ev[3]), .AO_WAVE_END(ev[4]), .CTR0_SOURCE_SEL(s0),
    .CTR0_GATE_SEL(g0), .CTR1_SOURCE_SEL(s1), .CTR1_GATE_SEL(g1), .CTR0_OUT_IN(c0), .CTR1_OUT_IN(c1),
    .FREQ_GEN_IN(fq), .STROBE_TOGGLE(ev[5]), .SCAN_CLOCK_OUT(sco), .EXTERNAL_STROBE_N(stb_n),
    .COUNTER0_OUTPUT(c0o), .COUNTER1_OUTPUT(c1o), .FREQ_GENERATOR_OUTPUT(fqo), .ACQ_PRE_PHASE(pre),
    .ACQ_POST_PHASE(post));

  tspr_ext_instr ext (.drv_en(drv_en), .drv_val(drv_val), .pin_out(pout), .pin_oe_n(oe_n), .pad(pad));

  // edge counters on the pulse outputs
  always @(posedge sco) n_scan++;
  always @(negedge pout[2]) n_conv++;
  always @(negedge pout[5]) n_upd++;
  always @(posedge pout[7]) n_ss++;

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step

  task automatic fire(input int k);
    ev[k] = 1'b1;
    step(1);
    ev = '0;
  endtask : fire

  task automatic t_pins();
    chk(oe_n, 10'h3FF);
    chk(sco, 1'b0);
    chk(stb_n, 1'b1);
    dir = 10'h2A5;
    drv_en = 10'h0FF;
    drv_val = 10'h0C3;
    step(1);
    chk(oe_n, ~dir);
    step(1);
    chk(routed, ((drv_val & drv_en) | ~drv_en) & ~dir);
    dir = 10'h3FF;
    step(2);
    chk(routed, 10'h000);
  endtask : t_pins

  task automatic t_copies();
    for (int i = 0; i < 2; i++) begin
      {s1, g1, s0, g0, c0, c1, fq} = (i == 0) ? 7'h4D : 7'h32;
      step(1);
      chk({c0o, c1o, fqo}, {c0, c1, fq});
      step(1);
      chk({pout[9:8], pout[4:3]}, {g0, s0, g1, s1});
    end
  endtask : t_copies

  task automatic t_strobe();
    fire(5);
    chk(stb_n, 1'b0);
    step(3);
    chk(stb_n, 1'b0);
    fire(5);
    chk(stb_n, 1'b1);
  endtask : t_strobe

  task automatic t_acq(input logic pt);
    pretrig = pt;
    fire(0);
    chk(pre, pt);
    chk(post, !pt);
    chk(pout[1:0], 2'b00);
    step(1);
    chk(pout[1:0], 2'b01);
    fire(1);
    chk({pre, post}, 2'b01);
    step(1);
    chk(pout[1:0], {pt, 1'b1});
    fire(2);
    step(1);
    chk(pout[1:0], 2'b00);
    chk({pre, post}, 2'b00);
  endtask : t_acq

  task automatic t_wave();
    fire(3);
    step(1);
    chk(pout[6], 1'b1);
    fire(4);
    step(1);
    chk(pout[6], 1'b0);
  endtask : t_wave

  task automatic t_pulses();
    n_scan = 0;
    n_conv = 0;
    n_upd = 0;
    n_ss = 0;
    scan_mode = 1'b1;
    scan_en = 1'b1;
    ev[6] = 1'b1;
    step(3);
    ev = '0;
    step(20);
    chk(10'(n_scan), 10'h003);
    chk(10'(n_conv), 10'h003);
    scan_en = 1'b0;
    fire(6);
    step(8);
    chk(10'(n_scan), 10'h003);
    chk(10'(n_conv), 10'h004);
    fire(7);
    step(1);
    fire(8);
    step(8);
    chk(10'(n_ss), 10'h001);
    chk(10'(n_upd), 10'h001);
  endtask : t_pulses

  task automatic results();
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    arst_n = 1'b0;
    ev = '0;
    dir = '0;
    drv_en = '0;
    drv_val = '0;
    scan_mode = 1'b0;
    scan_en = 1'b0;
    pretrig = 1'b0;
    {s1, g1, s0, g0, c0, c1, fq} = '0;
    err_count = 0;
    checks_done = 0;
    step(20);
    arst_n = 1'b1;
    t_pins();
    t_copies();
    t_strobe();
    t_acq(1'b1);
    t_acq(1'b0);
    t_wave();
    t_pulses();
    results();
  end

  initial begin
    #1ms;
    err_count++;
    results();
  end
endmodule : tspr_pin_router_test

`default_nettype wire
